// ===== core/ieg_pkg.sv
// Package with register map, field positions and types for the enable group
package ieg_pkg;

  // Register byte addresses on APB
  localparam logic [11:0] IEG_ADDR_ENABLE = 12'h000;
  localparam logic [11:0] IEG_ADDR_STATUS = 12'h004;
  localparam logic [11:0] IEG_ADDR_MASK   = 12'h008;
  localparam logic [11:0] IEG_ADDR_REQ    = 12'h00c;

  // Enable register field positions
  localparam int IEG_BIT_CHARGE_TIMER = 13;
  localparam int IEG_BIT_LOW_VOLTAGE  = 8;
  localparam int IEG_BIT_CRC_GEN      = 3;
  localparam int IEG_BIT_SERIAL_TWO   = 2;
  localparam int IEG_BIT_SERIAL_ONE   = 1;

  // Implemented bits and reset value
  localparam logic [15:0] IEG_IMPL_MASK   = 16'h210e;
  localparam logic [15:0] IEG_ENABLE_RST  = 16'h0000;
  localparam logic [15:0] IEG_STATUS_RST  = 16'h0000;
  localparam logic [15:0] IEG_MASK_RST    = 16'h0000;

  // Number of bits in the source vector
  localparam int IEG_WIDTH = 16;

  // APB request bundle
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ieg_apb_req_s;

endpackage : ieg_pkg

// ===== core/ieg_gate_reg.sv
// Enable register with per-bit request gating
`timescale 1ns/1ps
module ieg_gate_reg
  import ieg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_in,
  // Write port
  input  wire logic        wr_in,
  input  wire logic [15:0] wdata_in,
  // Source requests
  input  wire logic [15:0] req_in,
  // Stored value and gated requests
  output logic      [15:0] enable_out,
  output logic      [15:0] gated_out
);

  logic      [15:0] enable;
  wire logic [15:0] next_enable;

  // Next value per bit; only implemented positions take write data
  genvar g;
  generate
    for (g = 0; g < IEG_WIDTH; g++) begin : g_bit
      if (IEG_IMPL_MASK[g]) begin : g_impl
        assign next_enable[g] = wr_in ? wdata_in[g] : enable[g];
      end else begin : g_none
        assign next_enable[g] = 1'b0;
      end
    end
  endgenerate

  // Enable storage, cleared at reset so every source starts blocked
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enable <= IEG_ENABLE_RST;
    end else begin
      enable <= next_enable;
    end
  end

  // Gated requests registered toward prioritisation
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      gated_out <= 16'h0000;
    end else begin
      gated_out <= req_in & enable;
    end
  end

  assign enable_out = enable;

endmodule : ieg_gate_reg

// ===== core/ieg_top.sv
// Interrupt enable group four: APB registers, gating and event interrupt
//
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ieg_top
  import ieg_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESET_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Source requests, level per source
  input  wire logic        CHARGE_TIMER_REQ_IN,
  input  wire logic        LOW_VOLTAGE_REQ_IN,
  input  wire logic        CRC_GEN_REQ_IN,
  input  wire logic        SERIAL_TWO_ERROR_REQ_IN,
  input  wire logic        SERIAL_ONE_ERROR_REQ_IN,
  // Gated requests toward prioritisation
  output logic      [15:0] GATED_REQ_OUT,
  // Summary interrupt
  output logic             IRQ_OUT
);

  ieg_apb_req_s req;
  logic [15:0]  enable;
  logic [15:0]  gated;
  logic [15:0]  gated_q;
  logic [15:0]  status;
  logic [15:0]  mask;
  logic [15:0]  next_status;
  logic [15:0]  next_mask;
  logic [15:0]  gated_rise;
  logic [15:0]  src_vec;
  logic [31:0]  next_rdata;
  logic         setup;
  logic         access;

  // Address decode shared by write and read paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
    hit = (a == r);
  endfunction : hit

  // Bundle the bus request
  assign req = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
                 addr: PADDR_IN, wdata: PWDATA_IN};
  assign setup  = req.sel && !req.enable;
  assign access = req.sel && req.enable && PREADY_OUT;

  // Write strobes, taken on the access edge
  wire wr_enable = access && req.write && hit(req.addr, IEG_ADDR_ENABLE);
  wire wr_status = access && req.write && hit(req.addr, IEG_ADDR_STATUS);
  wire wr_mask   = access && req.write && hit(req.addr, IEG_ADDR_MASK);
  wire mapped    = hit(req.addr, IEG_ADDR_ENABLE) || hit(req.addr, IEG_ADDR_STATUS)
                || hit(req.addr, IEG_ADDR_MASK)   || hit(req.addr, IEG_ADDR_REQ);

  // Source vector at documented bit positions
  always_comb begin
    src_vec = 16'h0000;
    src_vec[IEG_BIT_CHARGE_TIMER] = CHARGE_TIMER_REQ_IN;
    src_vec[IEG_BIT_LOW_VOLTAGE]  = LOW_VOLTAGE_REQ_IN;
    src_vec[IEG_BIT_CRC_GEN]      = CRC_GEN_REQ_IN;
    src_vec[IEG_BIT_SERIAL_TWO]   = SERIAL_TWO_ERROR_REQ_IN;
    src_vec[IEG_BIT_SERIAL_ONE]   = SERIAL_ONE_ERROR_REQ_IN;
  end

  // Enable storage and gating; the gate adds one flop and the output stage
  // another, so a source reaches the port two cycles after it changes
  ieg_gate_reg u_gate (
    .clk_in     (CLK_SYS_IN),
    .reset_in   (RESET_IN),
    .wr_in      (wr_enable),
    .wdata_in   (PWDATA_IN[15:0]),
    .req_in     (src_vec),
    .enable_out (enable),
    .gated_out  (gated)
  );

  // Rising edge of each gated request; a level held high sets its bit once
  assign gated_rise = gated & ~gated_q;

  // Sticky status, write one to clear; a new edge in the clearing cycle wins
  assign next_status = ((status & ~(wr_status ? PWDATA_IN[15:0] : 16'h0000))
                       | gated_rise) & IEG_IMPL_MASK;

  // Mask keeps only implemented positions
  assign next_mask = wr_mask ? (PWDATA_IN[15:0] & IEG_IMPL_MASK) : mask;

  // Read mux
  assign next_rdata = hit(req.addr, IEG_ADDR_ENABLE) ? {16'h0000, enable}
                    : hit(req.addr, IEG_ADDR_STATUS) ? {16'h0000, status}
                    : hit(req.addr, IEG_ADDR_MASK)   ? {16'h0000, mask}
                    : hit(req.addr, IEG_ADDR_REQ)    ? {16'h0000, gated}
                    : 32'h0000_0000;

  // Status, mask and edge history
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      status  <= IEG_STATUS_RST;
      mask    <= IEG_MASK_RST;
      gated_q <= 16'h0000;
    end else begin
      status  <= next_status;
      mask    <= next_mask;
      gated_q <= gated;
    end
  end

  // Outputs from flops
  always_ff @(posedge CLK_SYS_IN) begin
    if (RESET_IN) begin
      PREADY_OUT    <= 1'b0;
      PRDATA_OUT    <= 32'h0000_0000;
      PSLVERR_OUT   <= 1'b0;
      GATED_REQ_OUT <= 16'h0000;
      IRQ_OUT       <= 1'b0;
    end else begin
      PREADY_OUT    <= setup;
      PRDATA_OUT    <= (setup && !req.write) ? next_rdata : 32'h0000_0000;
      PSLVERR_OUT   <= setup && !mapped;
      GATED_REQ_OUT <= gated;
      IRQ_OUT       <= |(next_status & next_mask);  // Next values, so no lag after writes
    end
  end

  // Assertions
  a_charge_gate: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (!enable[IEG_BIT_CHARGE_TIMER]) |=> !gated[IEG_BIT_CHARGE_TIMER])
    else $error("charge timer request passed while disabled");
  a_low_volt_gate: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (enable[IEG_BIT_LOW_VOLTAGE] && LOW_VOLTAGE_REQ_IN) |=> gated[IEG_BIT_LOW_VOLTAGE])
    else $error("low voltage request not forwarded");
  a_crc_gate: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ##1 gated[IEG_BIT_CRC_GEN] == $past(enable[IEG_BIT_CRC_GEN] && CRC_GEN_REQ_IN))
    else $error("crc request gating wrong");
  a_serial_two: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ##1 gated[IEG_BIT_SERIAL_TWO] == $past(enable[IEG_BIT_SERIAL_TWO] && SERIAL_TWO_ERROR_REQ_IN))
    else $error("serial two gating wrong");
  a_serial_one: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ##1 gated[IEG_BIT_SERIAL_ONE] == $past(enable[IEG_BIT_SERIAL_ONE] && SERIAL_ONE_ERROR_REQ_IN))
    else $error("serial one gating wrong");
  a_unimpl_zero: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    ((enable | status | mask | GATED_REQ_OUT) & ~IEG_IMPL_MASK) == 16'h0000)
    else $error("unimplemented bit holds a one");
  a_enable_write: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    wr_enable |=> enable == ($past(PWDATA_IN[15:0]) & IEG_IMPL_MASK))
    else $error("enable write not stored");
  a_reset_clear: assert property (@(posedge CLK_SYS_IN)
    RESET_IN |=> enable == 16'h0000 && !IRQ_OUT)
    else $error("enable not cleared by reset");
  a_ready_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    PREADY_OUT |=> !PREADY_OUT)
    else $error("pready held longer than one cycle");

  // Bus answer timing, error pairing and read data
  a_ready_after_setup: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (PSEL_IN && !PENABLE_IN) |=> PREADY_OUT)
    else $error("no ready after a setup cycle");
  a_ready_needs_setup: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    !(PSEL_IN && !PENABLE_IN) |=> !PREADY_OUT)
    else $error("ready without a setup cycle");
  a_error_with_ready: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    PSLVERR_OUT |-> PREADY_OUT)
    else $error("slave error outside an access cycle");
  a_rdata_idle: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    !PREADY_OUT |-> PRDATA_OUT == 32'h0000_0000)
    else $error("read data not zero while idle");
  a_unmapped_error: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (setup && !mapped) |=> PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_enable_read: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (setup && !PWRITE_IN && PADDR_IN == IEG_ADDR_ENABLE) |=>
    PRDATA_OUT == {16'h0000, $past(enable)})
    else $error("enable register read back wrong");
  a_req_view_read: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (setup && !PWRITE_IN && PADDR_IN == IEG_ADDR_REQ) |=>
    PRDATA_OUT == {16'h0000, $past(gated)})
    else $error("request view read back wrong");

  // Pin to port gating, two flops deep
  a_gate_ports: assert property (@(posedge CLK_SYS_IN)
    disable iff (RESET_IN) ##2 GATED_REQ_OUT == ($past(src_vec, 2) & $past(enable, 2)))
    else $error("gated request port does not follow enabled sources");

  // Status, mask and interrupt level
  a_status_set: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (|gated_rise) |=> (status & $past(gated_rise)) == $past(gated_rise))
    else $error("status bit not set by request edge");
  a_status_clear: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (wr_status && !(|gated_rise)) |=> (status & $past(PWDATA_IN[15:0])) == 16'h0000)
    else $error("status bit not cleared by write of one");
  a_status_sticky: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    !wr_status |=> (status & $past(status)) == $past(status))
    else $error("status bit lost without a clear");
  a_mask_write: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    wr_mask |=> mask == ($past(PWDATA_IN[15:0]) & IEG_IMPL_MASK))
    else $error("mask write not stored");
  a_irq_level: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    IRQ_OUT == |(status & mask))
    else $error("interrupt level does not match status and mask");
  a_unmapped_ignore: assert property (@(posedge CLK_SYS_IN) disable iff (RESET_IN)
    (access && req.write && !mapped) |=> $stable(enable) && $stable(mask))
    else $error("unmapped write changed a register");

  c_enable_write: cover property (@(posedge CLK_SYS_IN) wr_enable);
  c_irq_raised:   cover property (@(posedge CLK_SYS_IN) $rose(IRQ_OUT));
  c_status_clear: cover property (@(posedge CLK_SYS_IN) wr_status && |status);
  c_bad_addr:     cover property (@(posedge CLK_SYS_IN) PSLVERR_OUT);
  c_gate_pass:    cover property (@(posedge CLK_SYS_IN) |GATED_REQ_OUT);

endmodule : ieg_top

// ===== verification/ieg_tb.sv
// Self-checking testbench for the interrupt enable group registers
`timescale 1ns/1ps
module tb;
  import ieg_pkg::*;

  logic        clk    = 1'b0;
  logic        rst    = 1'b1;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [11:0] paddr  = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic [15:0] src    = 16'h0000;
  logic [15:0] gated;
  int          err_total = 0;
  int          cmp_count = 0;
  int          bits[5]   = '{IEG_BIT_CHARGE_TIMER, IEG_BIT_LOW_VOLTAGE, IEG_BIT_CRC_GEN,
                             IEG_BIT_SERIAL_TWO, IEG_BIT_SERIAL_ONE};

  // 50 MHz system clock
  always #10 clk = ~clk;

  // Block under test
  ieg_top dut (
    .CLK_SYS_IN(clk), .RESET_IN(rst),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .CHARGE_TIMER_REQ_IN(src[13]), .LOW_VOLTAGE_REQ_IN(src[8]), .CRC_GEN_REQ_IN(src[3]),
    .SERIAL_TWO_ERROR_REQ_IN(src[2]), .SERIAL_ONE_ERROR_REQ_IN(src[1]),
    .GATED_REQ_OUT(gated), .IRQ_OUT(irq)
  );

  // APB transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  // Compare one result against its expectation
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Print counts and verdict, then stop
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // Main sequence of tests
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0000_0000);
      chk({31'h0, err}, 32'h0);
    end
    $display("test reset values done");
    apb(1'b1, IEG_ADDR_ENABLE, 32'hffff_ffff);
    apb(1'b0, IEG_ADDR_ENABLE, 32'h0);
    chk(rd, {16'h0000, IEG_IMPL_MASK});
    apb(1'b1, IEG_ADDR_ENABLE, 32'h0000_0000);
    apb(1'b0, IEG_ADDR_ENABLE, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("test enable access done");
    src <= 16'hffff;
    repeat (3) @(posedge clk);
    chk({16'h0000, gated}, 32'h0000_0000);
    foreach (bits[i]) begin
      apb(1'b1, IEG_ADDR_ENABLE, 32'h1 << bits[i]);
      repeat (3) @(posedge clk);
      chk({16'h0000, gated}, 32'h1 << bits[i]);
      apb(1'b0, IEG_ADDR_REQ, 32'h0);
      chk(rd, 32'h1 << bits[i]);
    end
    apb(1'b1, IEG_ADDR_ENABLE, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({16'h0000, gated}, 32'h0000_0000);
    $display("test gating done");
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, IEG_ADDR_STATUS, 32'h0);
    chk(rd, {16'h0000, IEG_IMPL_MASK});
    apb(1'b1, IEG_ADDR_MASK, 32'h0000_0008);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, IEG_ADDR_STATUS, 32'h0000_ffff);
    apb(1'b0, IEG_ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, IEG_ADDR_MASK, 32'hffff_ffff);
    apb(1'b0, IEG_ADDR_MASK, 32'h0);
    chk(rd, {16'h0000, IEG_IMPL_MASK});
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h010, 32'hffff_ffff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, IEG_ADDR_ENABLE, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("test unmapped access done");
    print_verdict();
  end

  // Watchdog against a hung handshake
  initial begin
    #200000;
    err_total++;
    print_verdict();
  end

endmodule : tb
